// >>> verilog/irq_bank_pkg.sv
// interrupt flag and mask bank: shared offsets, layouts and reset values
// assumes a 32-bit avalon-mm slave port, one aligned word per register
package irq_bank_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_FLAGS_PORT_PINS = 5'h00;
  localparam logic [4:0] OFS_FLAGS_TIMEBASE = 5'h04;
  localparam logic [4:0] OFS_FLAGS_SUPPLY = 5'h08;
  localparam logic [4:0] OFS_ENABLE_PORT_PINS = 5'h0C;
  localparam logic [4:0] OFS_ENABLE_TIMEBASE = 5'h10;
  localparam logic [4:0] OFS_ENABLE_SUPPLY = 5'h14;
  localparam logic [4:0] OFS_CORE_CTRL = 5'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SLOW_TICK = 3;
  localparam int BIT_FAST_TICK = 2;
  localparam int BIT_NVM_DONE = 1;
  localparam int BIT_CONV_DONE = 0;
  localparam int BIT_SUPPLY_DONE = 2;
  localparam int BIT_CNT_ZERO = 1;
  localparam int BIT_CNT_MATCH = 0;
  localparam int BIT_GLOBAL_EN = 0;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [3:0] SUPPLY_USED = 4'h7;

endpackage : irq_bank_pkg

// >>> verilog/rise_detect.sv
// rising edge detector for a group of synchronous request lines
// assumes the lines are synchronous to the clock
`timescale 1ns/100ps
module rise_detect
  import irq_bank_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // request lines
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] prev_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_ff;

endmodule : rise_detect

// >>> verilog/flag_nibble.sv
// one 4-bit request flag register with per-bit enable, w1c and read clear
// assumes edges arrive as one-cycle pulses
`timescale 1ns/100ps
module flag_nibble
  import irq_bank_pkg::*;
#(
  parameter logic [3:0] USED = 4'hF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // sources and controls
  input wire logic [3:0] edge_i,
  input wire logic [3:0] enable_i,
  input wire logic [3:0] clear_i,
  // state
  output logic [3:0] flags_o
);

  logic [3:0] flags_ff;
  logic [3:0] nxt_flags;

  genvar g;
  generate
    for (g = 0; g < NIB_W; g++) begin : g_bit
      // set beats clear; masked edges dropped
      assign nxt_flags[g] = USED[g] & ((edge_i[g] & enable_i[g]) |
                            (flags_ff[g] & ~clear_i[g]));
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_ff <= FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_o = flags_ff;

endmodule : flag_nibble

// >>> verilog/irq_flag_mask_bank.sv
// interrupt request flag and mask bank, avalon-mm slave
// assumes request sources are synchronous levels on ref_clk_i
//
// Contract
// - a 4-bit flag register records a request per input port pin, reset 0.
// - a second flag register holds slow tick, fast tick, nvm, conversion.
// - a third flag register holds supply check, counter zero, match.
// - writing one to a flag bit clears it, writing zero leaves it; a bit whose edge lands in the write cycle stays set.
// - a read/write mask register enables each port pin request, reset 0.
// - a second mask register enables tick, nvm and conversion requests.
// - a third mask register enables supply and counter requests.
// - a source event while its mask is zero is discarded.
// - the cpu interrupt is a set flag and the global enable together.
// - flags set only on a rising source edge with the mask set.
// - reading a flag register returns it and clears that register; a bit whose edge lands in the read cycle stays set.
`timescale 1ns/100ps
module irq_flag_mask_bank
  import irq_bank_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // request sources
  input wire logic [3:0] input_port_first_i,
  input wire logic slow_tick_i,
  input wire logic fast_tick_i,
  input wire logic nvm_write_done_i,
  input wire logic conversion_done_i,
  input wire logic supply_check_done_i,
  input wire logic counter_zero_i,
  input wire logic counter_match_i,
  // core side
  input wire logic halt_entry_i,
  output logic cpu_irq_o
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } bus_state_e;

  bus_state_e state_ff;
  logic [31:0] rdata_ff;
  logic [1:0] resp_ff;
  logic req;
  logic take;
  logic wr_take;
  logic rd_take;
  logic hit_known;
  logic [31:0] rd_mux;

  assign req = avs_read_i | avs_write_i;
  assign take = (state_ff == ST_IDLE) & req;
  assign wr_take = take & avs_write_i & avs_byteenable_i[0];
  assign rd_take = take & avs_read_i;

  // one wait cycle, then answer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_o = ~(state_ff == ST_DONE);

  // ----------------------------------------------------------------
  // mask and control registers
  // ----------------------------------------------------------------
  logic [3:0] pin_request_enable_ff;
  logic [3:0] tb_enable_ff;
  logic [3:0] supply_enable_ff;
  logic global_irq_enable_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_request_enable_ff <= ENABLE_RST;
      tb_enable_ff <= ENABLE_RST;
      supply_enable_ff <= ENABLE_RST;
    end else if (wr_take) begin
      case (avs_address_i)
        OFS_ENABLE_PORT_PINS: pin_request_enable_ff <= avs_writedata_i[3:0];
        OFS_ENABLE_TIMEBASE: tb_enable_ff <= avs_writedata_i[3:0];
        OFS_ENABLE_SUPPLY: begin
          supply_enable_ff <= avs_writedata_i[3:0] & SUPPLY_USED;
        end
        default: ;
      endcase
    end
  end

  // halt entry forces the enable on
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_irq_enable_ff <= 1'b0;
    end else if (halt_entry_i) begin
      global_irq_enable_ff <= 1'b1;
    end else if (wr_take && avs_address_i == OFS_CORE_CTRL) begin
      global_irq_enable_ff <= avs_writedata_i[BIT_GLOBAL_EN];
    end
  end

  // ----------------------------------------------------------------
  // edge detect and flags
  // ----------------------------------------------------------------
  logic [3:0] pin_rise;
  logic [3:0] tb_rise;
  logic [3:0] sup_rise;
  logic [3:0] tb_level;
  logic [3:0] sup_level;
  logic [3:0] pin_request_flag;
  logic [3:0] tb_flags;
  logic [3:0] sup_flags;
  logic [3:0] clr_pin;
  logic [3:0] clr_tb;
  logic [3:0] clr_sup;

  always_comb begin
    tb_level = '0;
    tb_level[BIT_SLOW_TICK] = slow_tick_i;
    tb_level[BIT_FAST_TICK] = fast_tick_i;
    tb_level[BIT_NVM_DONE] = nvm_write_done_i;
    tb_level[BIT_CONV_DONE] = conversion_done_i;
    sup_level = '0;
    sup_level[BIT_SUPPLY_DONE] = supply_check_done_i;
    sup_level[BIT_CNT_ZERO] = counter_zero_i;
    sup_level[BIT_CNT_MATCH] = counter_match_i;
  end

  rise_detect #(.WIDTH(12)) u_rise (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .level_i({sup_level, tb_level, input_port_first_i}),
    .rise_o({sup_rise, tb_rise, pin_rise})
  );

  // write-one clears the bit, a read clears the whole register
  function automatic logic [3:0] clr_of(input logic [4:0] ofs);
    logic [3:0] c;
    c = '0;
    if (wr_take && avs_address_i == ofs) begin
      c = avs_writedata_i[3:0];
    end
    if (rd_take && avs_address_i == ofs) begin
      c = 4'hF;
    end
    return c;
  endfunction : clr_of

  // always_comb follows the bus signals read inside clr_of
  always_comb begin
    clr_pin = clr_of(OFS_FLAGS_PORT_PINS);
    clr_tb = clr_of(OFS_FLAGS_TIMEBASE);
    clr_sup = clr_of(OFS_FLAGS_SUPPLY);
  end

  flag_nibble #(.USED(4'hF)) u_pin_flags (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .edge_i(pin_rise),
    .enable_i(pin_request_enable_ff),
    .clear_i(clr_pin),
    .flags_o(pin_request_flag)
  );

  flag_nibble #(.USED(4'hF)) u_tb_flags (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .edge_i(tb_rise),
    .enable_i(tb_enable_ff),
    .clear_i(clr_tb),
    .flags_o(tb_flags)
  );

  flag_nibble #(.USED(SUPPLY_USED)) u_sup_flags (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .edge_i(sup_rise),
    .enable_i(supply_enable_ff),
    .clear_i(clr_sup),
    .flags_o(sup_flags)
  );

  // ----------------------------------------------------------------
  // read data and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    hit_known = 1'b1;
    case (avs_address_i)
      OFS_FLAGS_PORT_PINS: rd_mux[3:0] = pin_request_flag;
      OFS_FLAGS_TIMEBASE: rd_mux[3:0] = tb_flags;
      OFS_FLAGS_SUPPLY: rd_mux[3:0] = sup_flags;
      OFS_ENABLE_PORT_PINS: rd_mux[3:0] = pin_request_enable_ff;
      OFS_ENABLE_TIMEBASE: rd_mux[3:0] = tb_enable_ff;
      OFS_ENABLE_SUPPLY: rd_mux[3:0] = supply_enable_ff;
      OFS_CORE_CTRL: rd_mux[BIT_GLOBAL_EN] = global_irq_enable_ff;
      default: hit_known = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
      resp_ff <= 2'h0;
    end else if (take) begin
      rdata_ff <= avs_read_i ? rd_mux : 32'h0000_0000;
      resp_ff <= hit_known ? 2'h0 : 2'h3;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_response_o = resp_ff;

  logic irq_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= global_irq_enable_ff &
                (|{pin_request_flag, tb_flags, sup_flags});
    end
  end
  assign cpu_irq_o = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_masked_pin_drop: assert property (
    (!pin_request_flag[0] && !pin_request_enable_ff[0])
      |=> !pin_request_flag[0])
    else $error("masked pin edge set flag");
  a_pin_edge_set: assert property (
    (pin_rise[0] && pin_request_enable_ff[0]) |=> pin_request_flag[0])
    else $error("enabled pin edge lost");
  a_tb_edge_set: assert property (
    (tb_rise[BIT_SLOW_TICK] && tb_enable_ff[BIT_SLOW_TICK])
      |=> tb_flags[BIT_SLOW_TICK])
    else $error("slow tick edge lost");
  a_supply_top_zero: assert property (
    !sup_flags[3] && !supply_enable_ff[3])
    else $error("unused supply bit set");
  a_w1c_clear: assert property (
    (wr_take && avs_address_i == OFS_FLAGS_PORT_PINS &&
     avs_writedata_i[0] && !pin_rise[0]) |=> !pin_request_flag[0])
    else $error("write one did not clear");
  a_w0_keep: assert property (
    (wr_take && avs_address_i == OFS_FLAGS_TIMEBASE &&
     !avs_writedata_i[BIT_FAST_TICK] && tb_flags[BIT_FAST_TICK])
      |=> tb_flags[BIT_FAST_TICK])
    else $error("write zero cleared flag");
  a_mask_write: assert property (
    (wr_take && avs_address_i == OFS_ENABLE_PORT_PINS) |=>
      pin_request_enable_ff == $past(avs_writedata_i[3:0]))
    else $error("mask write not stored");
  a_tb_mask_write: assert property (
    (wr_take && avs_address_i == OFS_ENABLE_TIMEBASE) |=>
      tb_enable_ff == $past(avs_writedata_i[3:0]))
    else $error("tb mask write not stored");
  a_sup_mask_write: assert property (
    (wr_take && avs_address_i == OFS_ENABLE_SUPPLY) |=>
      supply_enable_ff == ($past(avs_writedata_i[3:0]) & SUPPLY_USED))
    else $error("supply mask write not stored");
  a_irq_needs_en: assert property (
    cpu_irq_o |-> $past(global_irq_enable_ff))
    else $error("irq without global enable");
  a_read_clears: assert property (
    (rd_take && avs_address_i == OFS_FLAGS_SUPPLY && sup_rise == 4'h0)
      |=> sup_flags == 4'h0)
    else $error("read did not clear");
  a_halt_enable: assert property (
    halt_entry_i |=> global_irq_enable_ff)
    else $error("halt did not enable");
  a_set_wins: assert property (
    (pin_rise[2] && pin_request_enable_ff[2] && clr_pin[2])
      |=> pin_request_flag[2])
    else $error("set lost to clear");

  c_pin_irq: cover property (pin_request_flag[0] ##1 cpu_irq_o);
  c_read_clear: cover property (rd_take && sup_flags != 4'h0);
  c_halt: cover property (halt_entry_i ##1 cpu_irq_o);

endmodule : irq_flag_mask_bank

// >>> verif/irq_source_model.sv
// request source and cpu core model: request levels and halt entry
// assumes the bench calls its tasks from one sequential thread
`timescale 1ns/100ps
module irq_source_model (
  // clock
  input wire logic ref_clk_i,
  // levels: [10:7] pins, [6:3] slow fast nvm conv, [2:0] supply zero match
  output logic [10:0] level_o,
  output logic halt_o
);
  initial begin
    level_o = 11'h000;
    halt_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // one-cycle request on each selected source, then back low
  // ----------------------------------------------------------------
  task automatic pulse(input logic [10:0] sel);
    @(posedge ref_clk_i);
    level_o <= sel;
    @(posedge ref_clk_i);
    level_o <= 11'h000;
  endtask : pulse
  // set the request levels and leave them standing
  task automatic drive(input logic [10:0] sel);
    @(posedge ref_clk_i);
    level_o <= sel;
  endtask : drive
  task automatic halt();
    @(posedge ref_clk_i);
    halt_o <= 1'b1;
    @(posedge ref_clk_i);
    halt_o <= 1'b0;
  endtask : halt
endmodule : irq_source_model

// >>> verif/irq_flag_mask_bank_bench.sv
// self-checking bench for the interrupt flag and mask bank
// assumes the design package and irq_source_model are compiled first
`timescale 1ns/100ps
module irq_flag_mask_bank_bench;
  import irq_bank_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic [10:0] level;
  logic halt;
  logic cpu_irq;
  logic [31:0] rd;
  logic [1:0] resp;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  irq_source_model irq_source_model_i (
    .ref_clk_i(ref_clk),
    .level_o(level),
    .halt_o(halt)
  );
  irq_flag_mask_bank irq_flag_mask_bank_i (
    .ref_clk_i(ref_clk),
    .rst_i(rst),
    .avs_address_i(address),
    .avs_read_i(read),
    .avs_write_i(write),
    .avs_writedata_i(writedata),
    .avs_byteenable_i(byteenable),
    .avs_readdata_o(readdata),
    .avs_waitrequest_o(waitrequest),
    .avs_response_o(response),
    .input_port_first_i(level[10:7]),
    .slow_tick_i(level[6]),
    .fast_tick_i(level[5]),
    .nvm_write_done_i(level[4]),
    .conversion_done_i(level[3]),
    .supply_check_done_i(level[2]),
    .counter_zero_i(level[1]),
    .counter_match_i(level[0]),
    .halt_entry_i(halt),
    .cpu_irq_o(cpu_irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    rd = readdata;
    resp = response;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic summarize();
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cycles

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rdchk(5'(i * 4), 32'h0);
    rdchk(5'h1C, 32'h0);
    check(32'(resp), 32'h3);
  endtask : t_reset
  task automatic t_masks();
    bus(1'b1, OFS_ENABLE_PORT_PINS, 32'hF);
    bus(1'b1, OFS_ENABLE_TIMEBASE, 32'hF);
    bus(1'b1, OFS_ENABLE_SUPPLY, 32'hF);
    byteenable <= 4'hE;
    bus(1'b1, OFS_ENABLE_PORT_PINS, 32'h0);
    byteenable <= 4'hF;
    rdchk(OFS_ENABLE_PORT_PINS, 32'hF);
    rdchk(OFS_ENABLE_TIMEBASE, 32'hF);
    rdchk(OFS_ENABLE_SUPPLY, 32'(SUPPLY_USED));
  endtask : t_masks
  task automatic t_flags();
    irq_source_model_i.pulse(11'h7FF);
    wait_cycles(2);
    rdchk(OFS_FLAGS_PORT_PINS, 32'hF);
    rdchk(OFS_FLAGS_TIMEBASE, 32'hF);
    rdchk(OFS_FLAGS_SUPPLY, 32'(SUPPLY_USED));
    for (int i = 0; i < 3; i++) rdchk(5'(i * 4), 32'h0);
  endtask : t_flags
  task automatic t_w1c();
    irq_source_model_i.pulse(11'h7FF);
    bus(1'b1, OFS_FLAGS_PORT_PINS, 32'h5);
    bus(1'b1, OFS_FLAGS_TIMEBASE, 32'h3);
    bus(1'b1, OFS_FLAGS_SUPPLY, 32'h0);
    rdchk(OFS_FLAGS_PORT_PINS, 32'hA);
    rdchk(OFS_FLAGS_TIMEBASE, 32'hC);
    rdchk(OFS_FLAGS_SUPPLY, 32'h7);
  endtask : t_w1c
  task automatic t_race();
    fork
      irq_source_model_i.pulse(11'h200);
      bus(1'b0, OFS_FLAGS_PORT_PINS, 32'h0);
    join
    rdchk(OFS_FLAGS_PORT_PINS, 32'h4);
  endtask : t_race
  task automatic t_irq();
    irq_source_model_i.pulse(11'h400);
    wait_cycles(3);
    check(32'(cpu_irq), 32'h0);
    bus(1'b1, OFS_CORE_CTRL, 32'h1);
    wait_cycles(2);
    check(32'(cpu_irq), 32'h1);
    rdchk(OFS_FLAGS_PORT_PINS, 32'h8);
    wait_cycles(2);
    check(32'(cpu_irq), 32'h0);
    bus(1'b1, OFS_CORE_CTRL, 32'h0);
    irq_source_model_i.halt();
    wait_cycles(1);
    rdchk(OFS_CORE_CTRL, 32'h1);
  endtask : t_irq
  task automatic t_discard();
    bus(1'b1, OFS_ENABLE_PORT_PINS, 32'hA);
    bus(1'b1, OFS_ENABLE_TIMEBASE, 32'h0);
    bus(1'b1, OFS_ENABLE_SUPPLY, 32'h0);
    irq_source_model_i.pulse(11'h7FF);
    wait_cycles(2);
    rdchk(OFS_FLAGS_PORT_PINS, 32'hA);
    rdchk(OFS_FLAGS_TIMEBASE, 32'h0);
    rdchk(OFS_FLAGS_SUPPLY, 32'h0);
  endtask : t_discard
  task automatic t_level();
    irq_source_model_i.drive(11'h400);
    wait_cycles(2);
    rdchk(OFS_FLAGS_PORT_PINS, 32'h8);
    wait_cycles(3);
    rdchk(OFS_FLAGS_PORT_PINS, 32'h0);
    irq_source_model_i.drive(11'h000);
  endtask : t_level

  // ----------------------------------------------------------------
  // sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    wait_cycles(16);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_flags();
    t_w1c();
    t_race();
    t_irq();
    t_discard();
    t_level();
    summarize();
  end
endmodule : irq_flag_mask_bank_bench
